// ==== core/cpu_register_flags.sv ====
// Program-visible register set with flags word, ALU flag logic and APB slave
// Operation
// RULE1 - Carry flag follows carry out of or borrow into the result's top bit.
// RULE2 - Parity flag is set when the low result byte has an even count of ones.
// RULE3 - Aux carry flag follows carry or borrow across the low nibble.
// RULE4 - Zero flag is set exactly when every result bit is zero.
// RULE5 - Sign flag copies the result's top bit.
// RULE6 - Overflow flag marks a signed result that does not fit the operand size.
// RULE7 - With single-step set, a step interrupt follows the next instruction and clears that flag.
// RULE8 - Maskable interrupts are accepted only while the interrupt enable flag is set.
// RULE9 - String steps decrement the index registers when the direction flag is set, else increment.
// RULE10 - All status and control flags live in one 16-bit word at fixed bit positions.
// RULE11 - Eight 16-bit general registers exist, four of them also usable as two byte halves.
// RULE12 - Four 16-bit segment registers are provided.
// RULE13 - An instruction pointer holds the offset of the next instruction.
// RULE14 - All state is held without loss while the clock is stopped.
// RULE15 - Result flags update in the same cycle as the result write; other flags stay.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_flags (
	input wire logic clk, // 10 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire regflags_pkg::apb_req_t apb_req, // APB request
	output var regflags_pkg::apb_rsp_t apb_rsp, // APB answer
	input wire logic intr_pin, // Maskable interrupt request pin
	output logic irq, // Level interrupt
	output logic [15:0] flags_out // Flags word
);
	import regflags_pkg::*;

	state_t s;
	state_t n;
	cmd_t cmd;
	logic setup;
	logic acc;
	logic wr;
	logic exec;
	logic hit;
	logic gwin;
	logic swin;
	logic cin;
	logic sub;
	logic arith;
	logic cy;
	logic am;
	logic bm;
	logic rm;
	logic [15:0] opa;
	logic [15:0] opb;
	logic [15:0] res;
	logic [15:0] stp;
	logic [16:0] r;
	logic [31:0] rd;

	// Operand fetch; byte mode picks a half of the first four registers
	function automatic logic [15:0] get_op(input state_t st, input logic bo, input logic [2:0] i);
		get_op = st.gpr[i];
		if (bo) begin
			if (i[2]) begin
				get_op = {8'h00, st.gpr[{1'b0, i[1:0]}][15:8]};
			end else begin
				get_op = {8'h00, st.gpr[{1'b0, i[1:0]}][7:0]};
			end
		end
	endfunction

	// Whole next-state computation
	always_comb begin
		n = s;
		setup = apb_req.psel & ~apb_req.penable;
		acc = apb_req.psel & apb_req.penable & s.rsp.pready;
		wr = acc & apb_req.pwrite;
		cmd = cmd_t'(apb_req.pwdata);
		gwin = apb_req.paddr[7:5] == A_GPR_HI;
		swin = apb_req.paddr[7:4] == A_SEG_HI;
		hit = (apb_req.paddr[1:0] == 2'h0) & ((apb_req.paddr <= A_VEC) | gwin | swin);
		exec = wr & (apb_req.paddr == A_CMD);
		opa = get_op(s, cmd.byte_op, cmd.dst);
		opb = get_op(s, cmd.byte_op, cmd.src);
		sub = (cmd.op == OP_SUB) | (cmd.op == OP_SBB);
		arith = (cmd.op == OP_ADD) | (cmd.op == OP_ADC) | sub;
		cin = s.flags[CARRY_BIT] & ((cmd.op == OP_ADC) | (cmd.op == OP_SBB));
		// 17-bit result keeps carry or borrow out of a word
		case (cmd.op)
			OP_ADD, OP_ADC: begin
				r = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
			end
			OP_SUB, OP_SBB: begin
				r = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin};
			end
			OP_AND: begin
				r = {1'b0, opa & opb};
			end
			OP_OR: begin
				r = {1'b0, opa | opb};
			end
			OP_XOR: begin
				r = {1'b0, opa ^ opb};
			end
			default: begin
				r = '0;
			end
		endcase
		// Zero-extended bytes make a borrow show at bit 8 as well
		cy = cmd.byte_op ? r[BYTE_MSB+1] : r[WORD_MSB+1]; // RULE1
		am = cmd.byte_op ? opa[BYTE_MSB] : opa[WORD_MSB];
		bm = cmd.byte_op ? opb[BYTE_MSB] : opb[WORD_MSB];
		rm = cmd.byte_op ? r[BYTE_MSB] : r[WORD_MSB];
		res = cmd.byte_op ? {8'h00, r[7:0]} : r[15:0];
		stp = cmd.byte_op ? STEP_B : STEP_W;

		// APB read data latched in setup, so pready rises in the access cycle
		rd = '0;
		case (apb_req.paddr)
			A_FLAGS: begin
				rd = {16'h0000, s.flags};
			end
			A_IP: begin
				rd = {16'h0000, s.ip};
			end
			A_STS: begin
				rd = {30'h0, s.sts};
			end
			A_IEN: begin
				rd = {30'h0, s.ien};
			end
			A_VEC: begin
				rd = {16'h0000, s.vec};
			end
			default: begin
				if (gwin) begin
					rd = {16'h0000, s.gpr[apb_req.paddr[4:2]]};
				end else if (swin) begin
					rd = {16'h0000, s.seg[apb_req.paddr[3:2]]};
				end
			end
		endcase
		n.rsp.pready = setup;
		if (setup) begin
			n.rsp.prdata = hit ? rd : '0;
			n.rsp.pslverr = ~hit;
		end

		// Register writes; unmapped addresses are answered with pslverr and ignored
		if (wr & hit) begin
			case (apb_req.paddr)
				A_FLAGS: begin
					n.flags = apb_req.pwdata[15:0] & FLAGS_WMASK; // RULE10
				end
				A_IP: begin
					n.ip = apb_req.pwdata[15:0]; // RULE13
				end
				A_CLR: begin
					n.sts = s.sts & ~apb_req.pwdata[NSTS-1:0];
				end
				A_IEN: begin
					n.ien = apb_req.pwdata[NSTS-1:0];
				end
				A_VEC: begin
					n.vec = apb_req.pwdata[15:0];
				end
				default: begin
					if (gwin) begin
						n.gpr[apb_req.paddr[4:2]] = apb_req.pwdata[15:0]; // RULE11
					end else if (swin) begin
						n.seg[apb_req.paddr[3:2]] = apb_req.pwdata[15:0]; // RULE12
					end
				end
			endcase
		end

		// One command is one instruction
		if (exec) begin
			if (cmd.op == OP_STR) begin
				if (s.flags[DIR_BIT]) begin
					n.gpr[IDX_SRC] = s.gpr[IDX_SRC] - stp; // RULE9
					n.gpr[IDX_DST] = s.gpr[IDX_DST] - stp; // RULE9
				end else begin
					n.gpr[IDX_SRC] = s.gpr[IDX_SRC] + stp; // RULE9
					n.gpr[IDX_DST] = s.gpr[IDX_DST] + stp; // RULE9
				end
			end else begin
				// Result and flags land on the same edge
				if (!cmd.byte_op) begin
					n.gpr[cmd.dst] = r[15:0]; // RULE15
				end else if (cmd.dst[2]) begin
					n.gpr[{1'b0, cmd.dst[1:0]}][15:8] = r[7:0]; // RULE11
				end else begin
					n.gpr[{1'b0, cmd.dst[1:0]}][7:0] = r[7:0]; // RULE11
				end
				n.flags[CARRY_BIT] = arith & cy; // RULE1
				n.flags[PARITY_BIT] = ~^res[7:0]; // RULE2
				n.flags[AUX_BIT] = arith & (opa[NIB] ^ opb[NIB] ^ r[NIB]); // RULE3
				n.flags[ZERO_BIT] = res == 16'h0000; // RULE4
				n.flags[SIGN_BIT] = rm; // RULE5
				// Same signs in, other sign out; subtraction flips the rule
				if (sub) begin
					n.flags[OVF_BIT] = (am != bm) & (rm != am); // RULE6
				end else begin
					n.flags[OVF_BIT] = arith & (am == bm) & (rm != am); // RULE6
				end
			end
			// Step trap is taken right after the instruction
			if (s.flags[STEP_BIT]) begin
				n.flags[STEP_BIT] = 1'b0; // RULE7
				n.sts[STS_STEP] = 1'b1; // RULE7
			end
		end

		// Pin synchroniser; level changes once stages two and three agree
		n.sync = {s.sync[1:0], intr_pin};
		if (s.sync[2] == s.sync[1]) begin
			n.lvl = s.sync[1];
		end
		// One acceptance per request level; a masked request waits
		if (!s.lvl) begin
			n.served = 1'b0;
		end else if (!s.served & s.flags[IEN_BIT] & ~exec) begin
			n.ip = s.vec; // RULE8
			n.flags[IEN_BIT] = 1'b0; // RULE8
			n.served = 1'b1;
			n.sts[STS_INTR] = 1'b1; // RULE8
		end
		n.irq = |(n.sts & n.ien);
	end

	// Plain static flops; nothing decays with the clock stopped
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= ST_RST;
		end else begin
			s <= n; // RULE14
		end
	end

	assign apb_rsp = s.rsp;
	assign irq = s.irq;
	assign flags_out = s.flags;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence

	sequence s_answer;
		apb_rsp.pready ##1 !apb_rsp.pready;
	endsequence

	property p_apb_answer;
		s_setup |=> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("pready not one cycle after setup"); // APB answer timing, our own choice

	property p_carry;
		exec && cmd.op == OP_ADD && !cmd.byte_op |=>
			s.flags[CARRY_BIT] == (($past({1'b0, opa}) + $past({1'b0, opb})) > 17'h0FFFF);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong after word add"); // RULE1

	property p_borrow;
		exec && cmd.op == OP_SUB && !cmd.byte_op |=> s.flags[CARRY_BIT] == ($past(opb) > $past(opa));
	endproperty
	a_borrow: assert property (p_borrow) else $error("carry flag wrong after word subtract"); // RULE1

	property p_parity;
		exec && cmd.op != OP_STR && !cmd.byte_op |=> s.flags[PARITY_BIT] == ~^s.gpr[$past(cmd.dst)][7:0];
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong"); // RULE2

	property p_aux;
		exec && cmd.op == OP_ADD |=>
			s.flags[AUX_BIT] == (({1'b0, $past(opa[3:0])} + {1'b0, $past(opb[3:0])}) > 5'h0F);
	endproperty
	a_aux: assert property (p_aux) else $error("aux carry flag wrong after add"); // RULE3

	property p_zero;
		exec && cmd.op != OP_STR && !cmd.byte_op |=>
			s.flags[ZERO_BIT] == (s.gpr[$past(cmd.dst)] == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag differs from word result"); // RULE4

	property p_sign;
		exec && cmd.op != OP_STR && !cmd.byte_op |=> s.flags[SIGN_BIT] == s.gpr[$past(cmd.dst)][WORD_MSB];
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag differs from result top bit"); // RULE5

	property p_logic_ovf;
		exec && (cmd.op == OP_AND || cmd.op == OP_OR || cmd.op == OP_XOR) |=>
			!s.flags[OVF_BIT] && !s.flags[CARRY_BIT];
	endproperty
	a_logic_ovf: assert property (p_logic_ovf) else $error("logic op left overflow or carry set"); // RULE6

	property p_ovf_add;
		exec && cmd.op == OP_ADD && !cmd.byte_op |=> s.flags[OVF_BIT] ==
			($past(am) == $past(bm) && s.gpr[$past(cmd.dst)][WORD_MSB] != $past(am));
	endproperty
	a_ovf_add: assert property (p_ovf_add) else $error("overflow flag wrong after word add"); // RULE6

	property p_flags_mask;
		(s.flags & ~FLAGS_WMASK) == 16'h0000;
	endproperty
	a_flags_mask: assert property (p_flags_mask) else $error("flags bit outside the layout is set"); // RULE10

	property p_step;
		exec && s.flags[STEP_BIT] |=> !s.flags[STEP_BIT] && s.sts[STS_STEP] ##1 (irq == s.ien[STS_STEP]);
	endproperty
	a_step: assert property (p_step) else $error("single step trap not taken"); // RULE7

	property p_sts_sticky;
		s.sts[STS_STEP] && !(wr && apb_req.paddr == A_CLR && apb_req.pwdata[STS_STEP]) |=> s.sts[STS_STEP];
	endproperty
	a_sts_sticky: assert property (p_sts_sticky) else $error("step trap status lost without clear"); // RULE7

	property p_intr;
		$rose(s.sts[STS_INTR]) |-> $past(s.flags[IEN_BIT]) && s.ip == $past(s.vec) && !s.flags[IEN_BIT];
	endproperty
	a_intr: assert property (p_intr) else $error("interrupt accepted while masked"); // RULE8

	property p_intr_masked;
		!s.flags[IEN_BIT] |=> !$rose(s.sts[STS_INTR]);
	endproperty
	a_intr_masked: assert property (p_intr_masked) else $error("request taken with enable flag clear"); // RULE8

	property p_dir;
		exec && cmd.op == OP_STR && s.flags[DIR_BIT] |=>
			s.gpr[IDX_SRC] == $past(s.gpr[IDX_SRC]) - ($past(cmd.byte_op) ? STEP_B : STEP_W);
	endproperty
	a_dir: assert property (p_dir) else $error("string index not decremented"); // RULE9

	property p_dir_inc;
		exec && cmd.op == OP_STR && !s.flags[DIR_BIT] |=>
			s.gpr[IDX_DST] == $past(s.gpr[IDX_DST]) + ($past(cmd.byte_op) ? STEP_B : STEP_W);
	endproperty
	a_dir_inc: assert property (p_dir_inc) else $error("string index not incremented"); // RULE9

	property p_str_keep;
		exec && cmd.op == OP_STR |=> (s.flags & FLAGS_WMASK & ~(16'h0001 << STEP_BIT)) ==
			($past(s.flags) & FLAGS_WMASK & ~(16'h0001 << STEP_BIT));
	endproperty
	a_str_keep: assert property (p_str_keep) else $error("string step changed result flags"); // RULE15
endmodule
`default_nettype wire

// ==== shared/regflags_pkg.sv ====
// Package: register map, flag layout, command and state types of the register/flags block
`default_nettype none
package regflags_pkg;
	localparam int DW = 16;
	localparam int NGPR = 8;
	localparam int NSEG = 4;
	localparam int NSTS = 2;
	// APB byte addresses
	localparam logic [7:0] A_FLAGS = 8'h00;
	localparam logic [7:0] A_IP = 8'h04;
	localparam logic [7:0] A_CMD = 8'h08;
	localparam logic [7:0] A_STS = 8'h0C;
	localparam logic [7:0] A_CLR = 8'h10;
	localparam logic [7:0] A_IEN = 8'h14;
	localparam logic [7:0] A_VEC = 8'h18;
	// General registers at 0x20..0x3C, segment registers at 0x40..0x4C
	localparam logic [2:0] A_GPR_HI = 3'h1;
	localparam logic [3:0] A_SEG_HI = 4'h4;
	// Flag bit positions
	localparam int CARRY_BIT = 0;
	localparam int PARITY_BIT = 2;
	localparam int AUX_BIT = 4;
	localparam int ZERO_BIT = 6;
	localparam int SIGN_BIT = 7;
	localparam int STEP_BIT = 8;
	localparam int IEN_BIT = 9;
	localparam int DIR_BIT = 10;
	localparam int OVF_BIT = 11;
	localparam logic [15:0] FLAGS_WMASK = 16'h0FD5;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;
	localparam int NIB = 4;
	// Status bits
	localparam int STS_STEP = 0;
	localparam int STS_INTR = 1;
	// String index registers and their step sizes
	localparam int IDX_SRC = 6;
	localparam int IDX_DST = 7;
	localparam logic [15:0] STEP_B = 16'h0001;
	localparam logic [15:0] STEP_W = 16'h0002;

	typedef enum logic [2:0] {OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_AND, OP_OR, OP_XOR, OP_STR} alu_op_t;

	typedef struct packed {
		logic [21:0] rsv;
		logic [2:0] src;
		logic [2:0] dst;
		logic byte_op;
		alu_op_t op;
	} cmd_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] ip;
		logic [15:0] vec;
		logic [NGPR-1:0][15:0] gpr;
		logic [NSEG-1:0][15:0] seg;
		logic [NSTS-1:0] sts;
		logic [NSTS-1:0] ien;
		apb_rsp_t rsp;
		logic irq;
		logic [2:0] sync;
		logic lvl;
		logic served;
	} state_t;

	localparam state_t ST_RST = '0;
endpackage
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the register set, flags word and APB slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
	import regflags_pkg::*;
	logic clk;
	logic nrst;
	logic run;
	logic intr_pin;
	logic irq;
	logic [15:0] flags_out;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [31:0] rdata;
	logic rerr;
	int num_errors;
	int checked;
	int cyc;

	cpu_register_flags i_cpu_register_flags (
		.clk(clk),
		.nrst(nrst),
		.apb_req(req),
		.apb_rsp(rsp),
		.intr_pin(intr_pin),
		.irq(irq),
		.flags_out(flags_out)
	);

	// Clock that can be frozen in either phase
	initial begin
		clk = 1'b0;
		forever begin
			#50;
			if (run) clk = ~clk;
		end
	end

	task automatic end_sim();
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, far above the run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// One APB transfer; request held until pready is seen, only the hang guard ends a wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (rsp.pready !== 1'b1);
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, {16'h0000, d});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		`CHK(rdata, {16'h0000, e})
	endtask

	// Preload flags and operands, run one command, check result and flags
	task automatic alu(input alu_op_t op, input logic bm, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] fin, input logic [15:0] res, input logic [15:0] fout);
		cmd_t c;
		c = '{rsv: 22'h0, src: 3'h1, dst: 3'h0, byte_op: bm, op: op};
		wr(A_FLAGS, fin);
		wr(8'h20, a);
		wr(8'h24, b);
		xfer(1'b1, A_CMD, 32'(c));
		rd_chk(8'h20, res);
		`CHK(flags_out, fout)
	endtask

	initial begin
		run = 1'b1;
		nrst = 1'b0;
		intr_pin = 1'b0;
		req = '0;
		num_errors = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		`CHK(flags_out, 16'h0000)
		`CHK(irq, 1'b0)
		// Register file: distinct values in every general and segment register
		for (int i = 0; i < NGPR; i++) wr(8'h20 + 8'(4 * i), 16'hA100 + 16'(i));
		for (int i = 0; i < NSEG; i++) wr(8'h40 + 8'(4 * i), 16'h5E00 + 16'(i));
		for (int i = 0; i < NGPR; i++) rd_chk(8'h20 + 8'(4 * i), 16'hA100 + 16'(i));
		for (int i = 0; i < NSEG; i++) rd_chk(8'h40 + 8'(4 * i), 16'h5E00 + 16'(i));
		wr(A_IP, 16'h0055);
		rd_chk(A_IP, 16'h0055);
		// Only the documented flag bits are writable
		wr(A_FLAGS, 16'hFFFF);
		rd_chk(A_FLAGS, 16'h0FD5);
		// Unmapped and unaligned places are refused
		xfer(1'b0, 8'h1C, 32'h0);
		`CHK(rerr, 1'b1)
		`CHK(rdata, 32'h0)
		xfer(1'b0, 8'h21, 32'h0);
		`CHK(rerr, 1'b1)
		// Arithmetic and logic flag cases; control bits ride through
		alu(OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 16'h0400, 16'h0000, 16'h0455);
		alu(OP_SUB, 1'b0, 16'h8000, 16'h0001, 16'h0000, 16'h7FFF, 16'h0814);
		alu(OP_ADD, 1'b1, 16'h127F, 16'h0001, 16'h0000, 16'h1280, 16'h0890);
		alu(OP_ADC, 1'b0, 16'h0001, 16'h0001, 16'h0001, 16'h0003, 16'h0004);
		alu(OP_SBB, 1'b0, 16'h0005, 16'h0003, 16'h0001, 16'h0001, 16'h0000);
		alu(OP_AND, 1'b0, 16'hFF0F, 16'h8F0F, 16'h0011, 16'h8F0F, 16'h0084);
		alu(OP_OR, 1'b0, 16'h0100, 16'h0000, 16'h0200, 16'h0100, 16'h0204);
		alu(OP_XOR, 1'b0, 16'h00F0, 16'h00F0, 16'h0801, 16'h0000, 16'h0044);
		// String steps both ways, flags untouched
		wr(8'h38, 16'h0010);
		wr(8'h3C, 16'h0010);
		wr(A_FLAGS, 16'h0455);
		xfer(1'b1, A_CMD, 32'(cmd_t'{rsv: 22'h0, src: 3'h0, dst: 3'h0, byte_op: 1'b1, op: OP_STR}));
		rd_chk(8'h38, 16'h000F);
		rd_chk(8'h3C, 16'h000F);
		`CHK(flags_out, 16'h0455)
		wr(A_FLAGS, 16'h0055);
		xfer(1'b1, A_CMD, 32'(cmd_t'{rsv: 22'h0, src: 3'h0, dst: 3'h0, byte_op: 1'b0, op: OP_STR}));
		rd_chk(8'h38, 16'h0011);
		// Single step: trap status, interrupt, mask and clear
		wr(A_IEN, 16'h0001);
		alu(OP_ADD, 1'b0, 16'h0000, 16'h0000, 16'h0100, 16'h0000, 16'h0044);
		rd_chk(A_STS, 16'h0001);
		`CHK(irq, 1'b1)
		wr(A_IEN, 16'h0000);
		rd_chk(A_STS, 16'h0001);
		`CHK(irq, 1'b0)
		wr(A_CLR, 16'h0001);
		wr(A_STS, 16'h0003);
		rd_chk(A_STS, 16'h0000);
		// Maskable request ignored while enable flag is clear
		wr(A_VEC, 16'h1234);
		wr(A_IEN, 16'h0002);
		wr(A_IP, 16'h0055);
		wr(A_FLAGS, 16'h0000);
		intr_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rd_chk(A_IP, 16'h0055);
		rd_chk(A_STS, 16'h0000);
		// Enable flag set: request accepted, vector loaded
		wr(A_FLAGS, 16'h0200);
		repeat (10) @(posedge clk);
		rd_chk(A_IP, 16'h1234);
		rd_chk(A_STS, 16'h0002);
		`CHK(flags_out, 16'h0000)
		`CHK(irq, 1'b1)
		intr_pin <= 1'b0;
		// Frozen clock in both phases keeps a general register and the IP
		wr(8'h2C, 16'hC0DE);
		@(posedge clk);
		run = 1'b0;
		#20000;
		run = 1'b1;
		@(negedge clk);
		run = 1'b0;
		#20000;
		run = 1'b1;
		rd_chk(8'h2C, 16'hC0DE);
		rd_chk(A_IP, 16'h1234);
		end_sim();
	end
endmodule
`default_nettype wire
